/* inc/pstd_pkg.sv */
// What this block does
// - Common ratio: highest request among active cores
// - Requests during a transition wait until done
// - Settle voltage first, then let PLL lock
// - Voltage from ratio and active core count
// - Voltage ramps one step per interval
// - Above base only on top-state request
// - Turbo cap: cores, current, power, temperature
// - Any limit hit caps ratio at base
// - Power above base only briefly
// - Average power tracked over long window
// - Per-core max turbo, readable by software
// - Per-core limit override raises interrupt
// - Fabric domain: three points by utilisation
// - Self-refresh DRAM before fabric rate change
// - Ring shares voltage with the cores
// - Ring ratio follows core and graphics
package pstd_pkg;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PWR  = 8'h04;
  localparam logic [7:0] OFS_ICT  = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQS = 8'h10;
  localparam logic [7:0] OFS_IRQM = 8'h14;
  localparam logic [7:0] OFS_REQ  = 8'h20;
  localparam logic [7:0] OFS_MAXT = 8'h40;
  // Reset values and fixed codes
  localparam logic [7:0]  BASE_RST  = 8'h10;
  localparam logic [7:0]  MAXT_RST  = 8'h30;
  localparam logic [15:0] BPWR_RST  = 16'h0100;
  localparam logic [15:0] STPL_RST  = 16'h0200;
  localparam logic [15:0] ICC_RST   = 16'h0400;
  localparam logic [7:0]  TEMP_RST  = 8'h64;
  localparam logic [7:0]  MIN_RATIO = 8'h04;
  localparam logic [7:0]  REQ_TOP   = 8'hFF;
  localparam logic [7:0]  VID_BASE  = 8'h20;
  localparam logic [7:0]  TURBO_BIN = 8'h01;
  localparam logic [7:0]  FAB_LO    = 8'h40;
  localparam logic [7:0]  FAB_HI    = 8'hA0;
  localparam int          AVG_SHIFT = 4;
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVR  = 1;
  localparam int IRQ_THR  = 2;
  localparam int IRQ_FAB  = 3;
  localparam int IRQ_W    = 4;
  // Timing
  localparam int CLK_NS       = 4;
  localparam int RAMP_STEP_NS = 20;
  localparam int RAMP_CYC     = (RAMP_STEP_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    XS_IDLE  = 2'b00,
    XS_VRAMP = 2'b01,
    XS_PLL   = 2'b11
  } pstd_xst_t;

  typedef enum logic [1:0] {
    FB_IDLE = 2'b00,
    FB_SR   = 2'b01,
    FB_UPD  = 2'b11,
    FB_EXIT = 2'b10
  } pstd_fst_t;

  typedef struct packed {
    logic [15:0] power;
    logic [15:0] current;
    logic [7:0]  temp;
  } pstd_telem_t;
endpackage

/* rtl/pstd_ctrl.sv */
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module pstd_ctrl #(
  parameter int NCORES = 4
) (
  // Clock and reset
  input  wire logic                     MCLK,
  input  wire logic                     SRST,
  // AHB-Lite slave
  input  wire logic                     HSEL,
  input  wire logic [pstd_pkg::ADDR_W-1:0] HADDR,
  input  wire logic [1:0]               HTRANS,
  input  wire logic                     HWRITE,
  input  wire logic [2:0]               HSIZE,
  input  wire logic [31:0]              HWDATA,
  input  wire logic                     HREADY,
  output logic      [31:0]              HRDATA,
  output logic                          HREADYOUT,
  output logic                          HRESP,
  // Core status and telemetry
  input  wire logic [NCORES-1:0]        CORE_ACTIVE,
  input  wire pstd_pkg::pstd_telem_t    TELEM,
  input  wire logic [7:0]               GFX_RATIO,
  input  wire logic [7:0]               MEM_UTIL,
  // Core supply and PLL
  output logic      [7:0]               VID,
  output logic      [7:0]               PLL_RATIO,
  input  wire logic                     PLL_LOCK,
  output logic                          BUSY,
  // Ring and last-level cache
  output logic      [7:0]               RING_RATIO,
  output logic      [7:0]               RING_VID,
  // Memory fabric
  output logic      [1:0]               FAB_POINT,
  output logic                          DRAM_SR_REQ,
  input  wire logic                     DRAM_SR_ACK,
  // Interrupt
  output logic                          IRQ
);
  import pstd_pkg::*;

  function automatic logic [7:0] popcnt(input logic [NCORES-1:0] v);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < NCORES; i++) begin
      n = n + {7'h00, v[i]};
    end
    return n;
  endfunction

  function automatic logic [7:0] vid_of(input logic [7:0] r,
                                        input logic [7:0] n);
    logic [9:0] s;
    s = {2'b00, r} + {1'b0, n, 1'b0} + {2'b00, VID_BASE};
    return (s > 10'h0FF) ? 8'hFF : s[7:0];
  endfunction

  function automatic logic [7:0] core_ofs(input logic [7:0] base,
                                          input int i);
    return base + 8'(i * 4);
  endfunction

  // Bus side state
  logic [ADDR_W-1:0] waddr_ff;
  logic              wr_ff;
  logic [31:0]       hrdata_ff;
  logic              hready_ff;
  logic [31:0]       rd_data;
  logic              acc;

  // Software registers
  logic              fab_en_ff;
  logic [7:0]        base_ff;
  logic [15:0]       bpwr_ff;
  logic [15:0]       stpl_ff;
  logic [15:0]       icc_ff;
  logic [7:0]        tlim_ff;
  logic [7:0]        req_ff  [NCORES];
  logic [7:0]        maxt_ff [NCORES];
  logic [IRQ_W-1:0]  irq_stat_ff;
  logic [IRQ_W-1:0]  irq_mask_ff;
  logic              irq_ff;

  // Operating point state
  pstd_xst_t         xst_ff;
  logic              busy_ff;
  logic [7:0]        tgt_ff;
  logic [7:0]        cur_ff;
  logic [7:0]        vid_ff;
  logic [7:0]        vtgt_ff;
  logic [7:0]        pll_ratio_ff;
  logic [7:0]        ramp_cnt_ff;
  logic [7:0]        ring_ratio_ff;
  logic [15:0]       avg_ff;
  logic              lim_ff;
  pstd_fst_t         fst_ff;
  logic [1:0]        fab_point_ff;
  logic [1:0]        fab_tgt_ff;
  logic              sr_req_ff;

  // Resolution
  logic [7:0]        act_cnt;
  logic [7:0]        req_max;
  logic [7:0]        turbo_cap;
  logic [7:0]        pen;
  logic [7:0]        resolved;
  logic              top_req;
  logic              ovr_wr;
  logic [1:0]        fab_want;
  logic              ev_done;
  logic              ev_fab;
  logic              limited;

  assign acc = HSEL & HTRANS[1] & HREADY;

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      wr_ff     <= 1'b0;
      waddr_ff  <= '0;
      hrdata_ff <= 32'h0000_0000;
      hready_ff <= 1'b0;
    end else begin
      // Read data is sampled in the address phase so there is no wait
      hready_ff <= 1'b1;
      wr_ff     <= acc & HWRITE;
      if (acc) begin
        waddr_ff <= HADDR;
      end
      if (acc & ~HWRITE) begin
        hrdata_ff <= rd_data;
      end
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (HADDR)
      OFS_CTRL: rd_data = {16'h0000, base_ff, 7'h00, fab_en_ff};
      OFS_PWR:  rd_data = {stpl_ff, bpwr_ff};
      OFS_ICT:  rd_data = {8'h00, tlim_ff, icc_ff};
      OFS_STAT: rd_data = {5'h00, lim_ff, fab_point_ff, vid_ff, cur_ff,
                           7'h00, busy_ff};
      OFS_IRQS: rd_data = {{(32 - IRQ_W){1'b0}}, irq_stat_ff};
      OFS_IRQM: rd_data = {{(32 - IRQ_W){1'b0}}, irq_mask_ff};
      default:  rd_data = 32'h0000_0000;
    endcase
    for (int i = 0; i < NCORES; i++) begin
      if (HADDR == core_ofs(OFS_REQ, i)) begin
        rd_data = {24'h000000, req_ff[i]};
      end
      if (HADDR == core_ofs(OFS_MAXT, i)) begin
        rd_data = {24'h000000, maxt_ff[i]};
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      fab_en_ff   <= 1'b0;
      base_ff     <= BASE_RST;
      bpwr_ff     <= BPWR_RST;
      stpl_ff     <= STPL_RST;
      icc_ff      <= ICC_RST;
      tlim_ff     <= TEMP_RST;
      irq_mask_ff <= '0;
    end else if (wr_ff) begin
      case (waddr_ff)
        OFS_CTRL: begin
          fab_en_ff <= HWDATA[0];
          base_ff   <= HWDATA[15:8];
        end
        OFS_PWR: begin
          bpwr_ff <= HWDATA[15:0];
          stpl_ff <= HWDATA[31:16];
        end
        OFS_ICT: begin
          icc_ff  <= HWDATA[15:0];
          tlim_ff <= HWDATA[23:16];
        end
        OFS_IRQM: irq_mask_ff <= HWDATA[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Per-core request and turbo ceiling registers
  always_ff @(posedge MCLK) begin
    for (int i = 0; i < NCORES; i++) begin
      if (SRST) begin
        req_ff[i]  <= MIN_RATIO;
        maxt_ff[i] <= MAXT_RST;
      end else begin
        if (wr_ff && waddr_ff == core_ofs(OFS_REQ, i)) begin
          req_ff[i] <= HWDATA[7:0];
        end
        if (wr_ff && waddr_ff == core_ofs(OFS_MAXT, i)) begin
          maxt_ff[i] <= HWDATA[7:0];
        end
      end
    end
  end

  always_comb begin
    ovr_wr = 1'b0;
    for (int i = 0; i < NCORES; i++) begin
      if (wr_ff && waddr_ff == core_ofs(OFS_MAXT, i)) begin
        ovr_wr = 1'b1;
      end
    end
  end

  // Long-window power average; short bursts up to the short-term
  // limit pass as long as the average stays under base power
  always_ff @(posedge MCLK) begin
    logic signed [17:0] diff;
    diff = $signed({2'b00, TELEM.power}) - $signed({2'b00, avg_ff});
    if (SRST) begin
      avg_ff <= 16'h0000;
      lim_ff <= 1'b0;
    end else begin
      avg_ff <= 16'($signed({2'b00, avg_ff}) + (diff >>> AVG_SHIFT));
      lim_ff <= limited;
    end
  end

  assign limited = (TELEM.current > icc_ff) | (TELEM.temp > tlim_ff) |
                   (TELEM.power > stpl_ff) | (avg_ff > bpwr_ff);

  always_comb begin
    act_cnt   = popcnt(CORE_ACTIVE);
    req_max   = MIN_RATIO;
    turbo_cap = 8'hFF;
    for (int i = 0; i < NCORES; i++) begin
      if (CORE_ACTIVE[i]) begin
        if (req_ff[i] > req_max) begin
          req_max = req_ff[i];
        end
        if (maxt_ff[i] < turbo_cap) begin
          turbo_cap = maxt_ff[i];
        end
      end
    end
    top_req = (req_max == REQ_TOP);
    // More active cores lower the reachable turbo bin
    pen = act_cnt * TURBO_BIN;
    if (!top_req) begin
      resolved = (req_max > base_ff) ? base_ff : req_max;
    end else if (lim_ff) begin
      resolved = base_ff;
    end else if ({1'b0, turbo_cap} > {1'b0, base_ff} + {1'b0, pen}) begin
      resolved = turbo_cap - pen;
    end else begin
      resolved = base_ff;
    end
  end

  // Transition sequencer: voltage first, then PLL relock
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      xst_ff       <= XS_IDLE;
      busy_ff      <= 1'b0;
      tgt_ff       <= MIN_RATIO;
      cur_ff       <= MIN_RATIO;
      vid_ff       <= VID_BASE;
      vtgt_ff      <= VID_BASE;
      pll_ratio_ff <= MIN_RATIO;
      ramp_cnt_ff  <= 8'h00;
      ev_done      <= 1'b0;
    end else begin
      ev_done <= 1'b0;
      case (xst_ff)
        XS_IDLE: begin
          // Later requests simply overwrite the resolved value
          if (resolved != cur_ff) begin
            tgt_ff      <= resolved;
            vtgt_ff     <= vid_of(resolved, act_cnt);
            ramp_cnt_ff <= 8'h00;
            busy_ff     <= 1'b1;
            xst_ff      <= XS_VRAMP;
          end
        end
        XS_VRAMP: begin
          if (vid_ff == vtgt_ff) begin
            pll_ratio_ff <= tgt_ff;
            xst_ff       <= XS_PLL;
          end else if (ramp_cnt_ff == 8'(RAMP_CYC - 1)) begin
            ramp_cnt_ff <= 8'h00;
            vid_ff <= (vid_ff < vtgt_ff) ? vid_ff + 8'h01
                                         : vid_ff - 8'h01;
          end else begin
            ramp_cnt_ff <= ramp_cnt_ff + 8'h01;
          end
        end
        XS_PLL: begin
          if (PLL_LOCK) begin
            cur_ff  <= tgt_ff;
            busy_ff <= 1'b0;
            ev_done <= 1'b1;
            xst_ff  <= XS_IDLE;
          end
        end
        default: xst_ff <= XS_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ring_ratio_ff <= MIN_RATIO;
    end else begin
      ring_ratio_ff <= 8'(({1'b0, cur_ff} + {1'b0, GFX_RATIO}) >> 1);
    end
  end

  assign fab_want = (MEM_UTIL > FAB_HI) ? 2'h2 :
                    (MEM_UTIL > FAB_LO) ? 2'h1 : 2'h0;

  // Fabric point changes only while DRAM sits in self-refresh
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      fst_ff       <= FB_IDLE;
      fab_point_ff <= 2'h2;
      fab_tgt_ff   <= 2'h2;
      sr_req_ff    <= 1'b0;
      ev_fab       <= 1'b0;
    end else begin
      ev_fab <= 1'b0;
      case (fst_ff)
        FB_IDLE: begin
          if (fab_en_ff && fab_want != fab_point_ff) begin
            fab_tgt_ff <= fab_want;
            sr_req_ff  <= 1'b1;
            fst_ff     <= FB_SR;
          end
        end
        FB_SR: begin
          if (DRAM_SR_ACK) begin
            fst_ff <= FB_UPD;
          end
        end
        FB_UPD: begin
          fab_point_ff <= fab_tgt_ff;
          ev_fab       <= 1'b1;
          fst_ff       <= FB_EXIT;
        end
        FB_EXIT: begin
          sr_req_ff <= 1'b0;
          if (!DRAM_SR_ACK) begin
            fst_ff <= FB_IDLE;
          end
        end
        default: fst_ff <= FB_IDLE;
      endcase
    end
  end

  // Sticky status, write one to clear; a same-cycle event wins
  always_ff @(posedge MCLK) begin
    logic [IRQ_W-1:0] ev;
    ev = '0;
    ev[IRQ_DONE] = ev_done;
    ev[IRQ_OVR]  = ovr_wr;
    ev[IRQ_THR]  = limited & ~lim_ff;
    ev[IRQ_FAB]  = ev_fab;
    if (SRST) begin
      irq_stat_ff <= '0;
      irq_ff      <= 1'b0;
    end else begin
      if (wr_ff && waddr_ff == OFS_IRQS) begin
        irq_stat_ff <= (irq_stat_ff & ~HWDATA[IRQ_W-1:0]) | ev;
      end else begin
        irq_stat_ff <= irq_stat_ff | ev;
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  assign HRDATA      = hrdata_ff;
  assign HREADYOUT   = hready_ff;
  assign HRESP       = 1'b0;
  assign VID         = vid_ff;
  assign RING_VID    = vid_ff;
  assign RING_RATIO  = ring_ratio_ff;
  assign PLL_RATIO   = pll_ratio_ff;
  assign BUSY        = busy_ff;
  assign FAB_POINT   = fab_point_ff;
  assign DRAM_SR_REQ = sr_req_ff;
  assign IRQ         = irq_ff;

  default clocking dc @(posedge MCLK); endclocking
  default disable iff (SRST);

  a_volt_first: assert property ($changed(pll_ratio_ff) |->
    vid_ff == vtgt_ff && $past(xst_ff) == XS_VRAMP)
    else $error("PLL ratio moved before voltage settled");
  a_ramp_rate: assert property ($changed(vid_ff) |=>
    $stable(vid_ff)[*4])
    else $error("Voltage stepped faster than ramp interval");
  a_vid_target: assert property ($rose(busy_ff) |->
    vtgt_ff == vid_of(tgt_ff, $past(act_cnt)))
    else $error("Voltage target not from ratio and core count");
  a_defer_hold: assert property (busy_ff && $past(busy_ff) |->
    $stable(tgt_ff))
    else $error("Target changed during a transition");
  a_busy_span: assert property ($fell(busy_ff) |->
    $past(PLL_LOCK) && cur_ff == pll_ratio_ff)
    else $error("Busy ended before PLL lock");
  a_turbo_gate: assert property ($rose(busy_ff) && tgt_ff > base_ff |->
    $past(top_req))
    else $error("Turbo ratio without top-state request");
  a_limit_cap: assert property (lim_ff |-> resolved <= base_ff)
    else $error("Ratio above base while limited");
  a_ovr_irq: assert property (ovr_wr |=> irq_stat_ff[IRQ_OVR])
    else $error("Turbo override did not raise status");
  a_sr_first: assert property ($changed(fab_point_ff) |->
    sr_req_ff && $past(DRAM_SR_ACK))
    else $error("Fabric point changed outside self-refresh");

  c_done: cover property ($fell(busy_ff));
  c_defer: cover property (busy_ff && resolved != tgt_ff);
  c_fab: cover property ($changed(fab_point_ff));
  c_irq: cover property ($rose(irq_ff));
endmodule
`default_nettype wire

/* verif/test_pstate_turbo_dvfs_control.sv */
`timescale 1ns/100ps
`default_nettype none
module test_pstate_turbo_dvfs_control;
  import pstd_pkg::*;
  localparam pstd_telem_t nom_tel = '{16'h0050, 16'h0100, 8'h30};
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0]  act = 4'h0;
  pstd_telem_t telem = nom_tel;
  logic [7:0]  gfx = 8'h08;
  logic [7:0]  util = 8'hB0;
  logic [7:0]  lk_ratio = 8'h04;
  logic [1:0]  lk_cnt = 2'h0;
  logic [2:0]  ack_sh = 3'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hready;
  logic        hresp;
  logic        busy;
  logic        sr_req;
  logic        irq;
  logic [7:0]  vid;
  logic [7:0]  pll;
  logic [7:0]  ring_r;
  logic [7:0]  ring_v;
  logic [1:0]  fab;
  logic [7:0]  req [4];
  logic [7:0]  maxt [4];
  logic        lim = 1'b0;
  integer      seed = 32'hC961;
  int          fails = 0;
  int          cmp_count = 0;
  int          nbusy = 0;
  int          gap = 99;
  logic [7:0]  vid_q = 8'h20;
  logic [7:0]  pll_q = 8'h04;
  logic [1:0]  fab_q = 2'h2;
  logic        busy_q = 1'b0;
  logic        ab_q = 1'b0;
  pstd_telem_t lt [4] = '{'{16'h0050, 16'h0500, 8'h30},
    '{16'h0050, 16'h0100, 8'h70}, '{16'h0250, 16'h0100, 8'h30},
    '{16'h0180, 16'h0100, 8'h30}};
  logic [7:0]  ut [6] = '{8'h30, 8'h40, 8'h41, 8'hA0, 8'hA1, 8'h10};
  logic [1:0]  fe [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h0};
  // Lock follows the ratio it last settled on, so it drops in the same
  // step the target moves and the controller can never see a stale lock
  wire logic   pll_lock;
  assign pll_lock = (pll === lk_ratio);

  pstd_ctrl #(.NCORES(4)) dut_u (
    .MCLK(mclk), .SRST(srst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .CORE_ACTIVE(act), .TELEM(telem), .GFX_RATIO(gfx), .MEM_UTIL(util),
    .VID(vid), .PLL_RATIO(pll), .PLL_LOCK(pll_lock), .BUSY(busy),
    .RING_RATIO(ring_r), .RING_VID(ring_v), .FAB_POINT(fab),
    .DRAM_SR_REQ(sr_req), .DRAM_SR_ACK(ack_sh[2]), .IRQ(irq));

  always #2 mclk = ~mclk;

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic tick(inout int n);
    @(posedge mclk);
    n++;
    if (n > 5000) begin
      fails++;
      report_and_stop();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= a;
    tick(n);
    while (hready !== 1'b1) tick(n);
    htrans <= 2'b00;
    hwdata <= d;
    tick(n);
    while (hready !== 1'b1) tick(n);
    rd = hrdata;
    cmp({31'h0, hresp}, 32'h0);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(rd & m, e);
  endtask

  task automatic sreq(input int i, input logic [7:0] v);
    req[i] = v;
    bus(1'b1, OFS_REQ + 8'(4 * i), {24'h0, v});
  endtask

  function automatic logic [7:0] resolve();
    int r;
    int m;
    r = 0;
    m = 255;
    for (int i = 0; i < 4; i++)
      if (act[i]) begin
        r = req[i] > r ? req[i] : r;
        m = maxt[i] < m ? maxt[i] : m;
      end
    if (act == 4'h0) return MIN_RATIO;
    if (lim) return BASE_RST;
    if (r != REQ_TOP) return r > BASE_RST ? BASE_RST : 8'(r);
    m = m - $countones(act) * TURBO_BIN;
    return m < BASE_RST ? BASE_RST : 8'(m);
  endfunction

  function automatic logic [7:0] vidx(input logic [7:0] r);
    int v;
    v = r + 2 * $countones(act) + VID_BASE;
    return v > 255 ? 8'hFF : 8'(v);
  endfunction

  task automatic settle(input string nm);
    int n;
    logic [7:0] r;
    r = resolve();
    n = 0;
    repeat (3) @(posedge mclk);
    while (busy !== 1'b0 || pll !== r) tick(n);
    @(posedge mclk);
    cmp({ring_v, ring_r}, {vid, 8'((9'(r) + 9'(gfx)) >> 1)});
    rdc(OFS_STAT, 32'h0000FF01, {16'h0, r, 8'h00});
    $display("test %s done", nm);
  endtask

  // Partner side and wire monitors share one clocked process
  always @(posedge mclk) begin
    ack_sh <= {ack_sh[1:0], sr_req};
    if (pll !== lk_ratio) begin
      if (lk_cnt == 2'h0)
        lk_ratio <= pll;
      else
        lk_cnt <= lk_cnt - 2'h1;
    end else
      lk_cnt <= 2'($random(seed));
    vid_q  <= vid;
    pll_q  <= pll;
    fab_q  <= fab;
    busy_q <= busy;
    ab_q   <= sr_req & ack_sh[2];
    gap    <= busy ? gap + 1 : 99;
    if (!srst && busy === 1'b1 && busy_q === 1'b0)
      nbusy <= nbusy + 1;
    if (!srst && vid !== vid_q) begin
      gap <= 0;
      cmp({31'h0, busy && gap >= RAMP_CYC - 1 && (vid - vid_q == 8'h01
          || vid_q - vid == 8'h01)}, 32'h1);
    end
    if (!srst && pll !== pll_q)
      cmp({busy, vid}, {1'b1, vidx(pll)});
    if (!srst && fab !== fab_q)
      cmp({31'h0, ab_q}, 32'h1);
  end

  initial begin
    int n;
    logic [7:0] u;
    for (int i = 0; i < 4; i++) begin
      req[i] = MIN_RATIO;
      maxt[i] = MAXT_RST;
    end
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    rdc(OFS_CTRL, '1, {16'h0, BASE_RST, 8'h00});
    rdc(OFS_PWR, '1, {STPL_RST, BPWR_RST});
    rdc(OFS_ICT, '1, {8'h00, TEMP_RST, ICC_RST});
    rdc(OFS_STAT, '1, {6'h0, 2'h2, VID_BASE, MIN_RATIO, 8'h00});
    rdc(OFS_MAXT + 8'h0C, '1, {24'h0, MAXT_RST});
    bus(1'b1, 8'h18, 32'hFFFFFFFF);
    rdc(8'h18, '1, 32'h0);
    $display("test reset done");
    act <= 4'b0101;
    sreq(0, 8'h0C);
    sreq(1, 8'hFF);
    settle("common");
    sreq(2, 8'h30);
    settle("cap");
    act <= 4'b0001;
    @(posedge mclk);
    settle("solo");
    nbusy = 0;
    sreq(0, 8'h06);
    sreq(0, 8'h0A);
    sreq(0, 8'h08);
    settle("defer");
    cmp(nbusy, 32'h2);
    act <= 4'b0011;
    sreq(0, 8'hFF);
    sreq(1, 8'hFF);
    settle("turbo");
    cmp({31'h0, irq}, 32'h0);
    bus(1'b1, OFS_IRQS, 32'hF);
    bus(1'b1, OFS_IRQM, 32'h2);
    maxt[1] = 8'h24;
    bus(1'b1, OFS_MAXT + 8'h04, 32'h24);
    rdc(OFS_MAXT + 8'h04, '1, 32'h24);
    settle("override");
    rdc(OFS_IRQS, 32'h3, 32'h3);
    cmp({31'h0, irq}, 32'h1);
    bus(1'b1, OFS_IRQS, 32'h2);
    repeat (2) @(posedge mclk);
    cmp({31'h0, irq}, 32'h0);
    for (int k = 0; k < 4; k++) begin
      telem <= lt[k];
      lim = 1'b1;
      @(posedge mclk);
      settle("limit");
      rdc(OFS_IRQS, 32'h4, 32'h4);
      bus(1'b1, OFS_IRQS, 32'h4);
      telem <= nom_tel;
      lim = 1'b0;
      @(posedge mclk);
      settle("recover");
    end
    // Power stays under base so only requests and cores steer the ratio
    repeat (8) begin
      act <= 4'($random(seed));
      gfx <= 8'($random(seed));
      telem <= '{16'($random(seed)) & 16'h00FF,
                 16'($random(seed)) & 16'h03FF, 8'($random(seed)) & 8'h3F};
      for (int i = 0; i < 4; i++) begin
        u = 8'($random(seed));
        sreq(i, u[7:6] == 2'b00 ? REQ_TOP : MIN_RATIO + (u & 8'h1F));
      end
      settle("random");
    end
    bus(1'b1, OFS_CTRL, {16'h0, BASE_RST, 8'h01});
    for (int k = 0; k < 6; k++) begin
      util <= ut[k];
      n = 0;
      repeat (3) @(posedge mclk);
      while (fab !== fe[k] || sr_req !== 1'b0 || ack_sh[2] !== 1'b0)
        tick(n);
      cmp({30'h0, fab}, {30'h0, fe[k]});
    end
    rdc(OFS_IRQS, 32'h8, 32'h8);
    $display("test fabric done");
    report_and_stop();
  end
endmodule
`default_nettype wire
